// *** src/bwc_defines.vh ***
// constants for the bandwidth floor and ceiling configuration store
// ==========================================================================
// Summary of operation
// - four separate ceiling instances, one per security space, reached from its own frame
// - four separate floor instances, one per security space, own partitions only
// - with instance selection, access indexes by instance and partition identifier
// - without instance selection, access indexes by partition identifier only
// - with narrowing, accesses use internal identifier; selector flag must be 1
// - without narrowing, accesses use request identifier; selector flag must be 0
// - ceiling register decoded at byte offset 0x0208 in every frame, read-write
// - floor register decoded at byte offset 0x0200 in every frame, read-write
// - root space floor and ceiling are read-write only with realm management
// - partition using less than its floor gets preferential access
// - floor exists only with partitioning and both capability flags; else reads zero
// - floor fraction in bits 15:0, bits 31:16 reserved
// - only top fraction-width bits implemented; lower bits read zero, ignore writes
// - unsigned fraction below one, binary point above bit 15
// - ceiling fraction in bits 15:0, hard-limit control in bit 31
// - hard limit set: partition over ceiling gets nothing until below ceiling
// - hard limit clear: partition over ceiling competes only at low preference
`ifndef BWC_DEFINES_VH
`define BWC_DEFINES_VH

// ==========================================================================
// frame offsets and security spaces
`define BWC_OFF_FLOOR   16'h0200
`define BWC_OFF_CEIL    16'h0208
`define BWC_SP_SECURE   2'h0
`define BWC_SP_NONSEC   2'h1
`define BWC_SP_ROOT     2'h2
`define BWC_SP_REALM    2'h3
`define BWC_NUM_SPACES  4

// ==========================================================================
// field layout
`define BWC_FRAC_MSB    15
`define BWC_FRAC_W      16
`define BWC_HLIM_BIT    31
`define BWC_FRAC_SPAN   5'h10
`define BWC_RSVD_FLR    16'h0000
`define BWC_RSVD_CEIL   15'h0000
`define BWC_FRAC_RESET  16'h0000
`define BWC_FRAC_ONES   16'hFFFF
`define BWC_WORD_ZERO   32'h0000_0000

// ==========================================================================
// storage geometry and capability defaults
`define BWC_PID_W       4
`define BWC_INST_W      1
`define BWC_IDX_W       5
`define BWC_DEPTH       32
`define BWC_PARTS       16
`define BWC_FRAC_WD_DEF 8

`endif

// *** src/bwc_top.v ***
// per-space bandwidth floor and ceiling store with arbiter preference lookup
`include "bwc_defines.vh"

module bwc_top #(
	parameter       instance_select_present = 1,
	parameter       narrowing_present       = 0,
	parameter       partitioning_feature    = 1,
	parameter       bw_partitioning_present = 1,
	parameter       floor_present           = 1,
	parameter       ceiling_present         = 1,
	parameter       realm_management_feature = 1,
	parameter [4:0] fraction_bit_width      = `BWC_FRAC_WD_DEF
) (
	input  wire        mclk,
	input  wire        sys_rst,
	// memory-mapped frame access
	input  wire        req_valid,
	input  wire        req_write,
	input  wire [1:0]  req_space,
	input  wire [15:0] req_addr,
	input  wire [31:0] req_wdata,
	// selector fields of the addressed space
	input  wire [15:0] selected_partition_field,
	input  wire [`BWC_INST_W-1:0] resource_instance_select,
	input  wire        sel_internal,
	// arbiter lookup
	input  wire        arb_valid,
	input  wire [1:0]  arb_space,
	input  wire [`BWC_INST_W-1:0] arb_instance,
	input  wire [`BWC_PID_W-1:0] arb_partition,
	input  wire [15:0] arb_usage,
	output reg         rsp_valid_q,
	output reg  [31:0] rsp_rdata_q,
	output reg         sel_error_q,
	output reg         arb_valid_q,
	output reg         arb_prefer_q,
	output reg         arb_low_pref_q,
	output reg         arb_block_q
);

// ==========================================================================
// helper functions

// storage index from instance and partition
function [`BWC_IDX_W-1:0] bwc_index;
	input [`BWC_INST_W-1:0] inst;
	input [`BWC_PID_W-1:0]  pid;
	begin
		if (instance_select_present != 0) begin
			bwc_index = {inst, pid};
		end else begin
			bwc_index = {{`BWC_INST_W{1'b0}}, pid};
		end
	end
endfunction

// mask of implemented fraction bits, left justified
function [`BWC_FRAC_W-1:0] bwc_frac_mask;
	input [4:0] wd;
	reg   [4:0] drop;
	begin
		drop = `BWC_FRAC_SPAN - wd;
		bwc_frac_mask = `BWC_FRAC_ONES << drop;
	end
endfunction

// ==========================================================================
// decode of frame accesses

localparam [`BWC_FRAC_W-1:0] FMASK = bwc_frac_mask(fraction_bit_width);
localparam FLR_ON = (partitioning_feature != 0) && (bw_partitioning_present != 0)
	&& (floor_present != 0);
localparam CEL_ON = (partitioning_feature != 0) && (bw_partitioning_present != 0)
	&& (ceiling_present != 0);

reg                    hit_flr;
reg                    hit_cel;
reg                    space_ok;
reg                    sel_ok;
reg                    pid_ok;
wire [`BWC_IDX_W-1:0]  req_idx;
wire [`BWC_IDX_W-1:0]  arb_idx;
wire                   acc_ok;
wire                   wr_flr;
wire                   wr_cel;

assign req_idx = bwc_index(resource_instance_select,
	selected_partition_field[`BWC_PID_W-1:0]);
assign arb_idx = bwc_index(arb_instance, arb_partition);

// offset, space and selector qualification
always @* begin
	hit_flr  = 1'b0;
	hit_cel  = 1'b0;
	space_ok = 1'b1;
	sel_ok   = 1'b0;
	pid_ok   = 1'b0;
	if (req_addr == `BWC_OFF_FLOOR) begin
		hit_flr = FLR_ON;
	end else if (req_addr == `BWC_OFF_CEIL) begin
		hit_cel = CEL_ON;
	end
	if (req_space == `BWC_SP_ROOT) begin
		space_ok = (realm_management_feature != 0);
	end
	if (narrowing_present != 0) begin
		sel_ok = sel_internal;
	end else begin
		sel_ok = !sel_internal;
	end
	pid_ok = (selected_partition_field < `BWC_PARTS);
end

assign acc_ok = req_valid && space_ok && sel_ok && pid_ok;
assign wr_flr = acc_ok && req_write && hit_flr;
assign wr_cel = acc_ok && req_write && hit_cel;

// ==========================================================================
// write data shared by the four spaces

wire [`BWC_FRAC_W-1:0]                 wr_frac;
wire                                   wr_hlim;
wire [`BWC_NUM_SPACES*`BWC_FRAC_W-1:0] flr_rd_all;
wire [`BWC_NUM_SPACES*`BWC_FRAC_W-1:0] cel_rd_all;
wire [`BWC_NUM_SPACES-1:0]             hl_rd_all;
wire [`BWC_NUM_SPACES*`BWC_FRAC_W-1:0] flr_arb_all;
wire [`BWC_NUM_SPACES*`BWC_FRAC_W-1:0] cel_arb_all;
wire [`BWC_NUM_SPACES-1:0]             hl_arb_all;

// only the implemented top bits of the fraction are kept
assign wr_frac = req_wdata[`BWC_FRAC_MSB:0] & FMASK;
assign wr_hlim = req_wdata[`BWC_HLIM_BIT];

// ==========================================================================
// secure space storage

reg  [`BWC_FRAC_W-1:0] flr_sec_q [0:`BWC_DEPTH-1];
reg  [`BWC_FRAC_W-1:0] cel_sec_q [0:`BWC_DEPTH-1];
reg                    hlm_sec_q [0:`BWC_DEPTH-1];
wire                   we_flr_sec;
wire                   we_cel_sec;
integer                i_sec;

// only the secure frame reaches these settings
assign we_flr_sec = wr_flr && (req_space == `BWC_SP_SECURE);
assign we_cel_sec = wr_cel && (req_space == `BWC_SP_SECURE);

// secure floor, ceiling and hard-limit settings
always @(posedge mclk) begin
	if (sys_rst) begin
		for (i_sec = 0; i_sec < `BWC_DEPTH; i_sec = i_sec + 1) begin
			flr_sec_q[i_sec] <= `BWC_FRAC_RESET;
			cel_sec_q[i_sec] <= `BWC_FRAC_RESET;
			hlm_sec_q[i_sec] <= 1'b0;
		end
	end else begin
		if (we_flr_sec) begin
			flr_sec_q[req_idx] <= wr_frac;
		end
		if (we_cel_sec) begin
			cel_sec_q[req_idx] <= wr_frac;
			hlm_sec_q[req_idx] <= wr_hlim;
		end
	end
end

// ==========================================================================
// non-secure space storage

reg  [`BWC_FRAC_W-1:0] flr_nsc_q [0:`BWC_DEPTH-1];
reg  [`BWC_FRAC_W-1:0] cel_nsc_q [0:`BWC_DEPTH-1];
reg                    hlm_nsc_q [0:`BWC_DEPTH-1];
wire                   we_flr_nsc;
wire                   we_cel_nsc;
integer                i_nsc;

// only the non-secure frame reaches these settings
assign we_flr_nsc = wr_flr && (req_space == `BWC_SP_NONSEC);
assign we_cel_nsc = wr_cel && (req_space == `BWC_SP_NONSEC);

// non-secure floor, ceiling and hard-limit settings
always @(posedge mclk) begin
	if (sys_rst) begin
		for (i_nsc = 0; i_nsc < `BWC_DEPTH; i_nsc = i_nsc + 1) begin
			flr_nsc_q[i_nsc] <= `BWC_FRAC_RESET;
			cel_nsc_q[i_nsc] <= `BWC_FRAC_RESET;
			hlm_nsc_q[i_nsc] <= 1'b0;
		end
	end else begin
		if (we_flr_nsc) begin
			flr_nsc_q[req_idx] <= wr_frac;
		end
		if (we_cel_nsc) begin
			cel_nsc_q[req_idx] <= wr_frac;
			hlm_nsc_q[req_idx] <= wr_hlim;
		end
	end
end

// ==========================================================================
// root space storage

reg  [`BWC_FRAC_W-1:0] flr_rot_q [0:`BWC_DEPTH-1];
reg  [`BWC_FRAC_W-1:0] cel_rot_q [0:`BWC_DEPTH-1];
reg                    hlm_rot_q [0:`BWC_DEPTH-1];
wire                   we_flr_rot;
wire                   we_cel_rot;
integer                i_rot;

// only the root frame reaches these settings
assign we_flr_rot = wr_flr && (req_space == `BWC_SP_ROOT);
assign we_cel_rot = wr_cel && (req_space == `BWC_SP_ROOT);

// root floor, ceiling and hard-limit settings
always @(posedge mclk) begin
	if (sys_rst) begin
		for (i_rot = 0; i_rot < `BWC_DEPTH; i_rot = i_rot + 1) begin
			flr_rot_q[i_rot] <= `BWC_FRAC_RESET;
			cel_rot_q[i_rot] <= `BWC_FRAC_RESET;
			hlm_rot_q[i_rot] <= 1'b0;
		end
	end else begin
		if (we_flr_rot) begin
			flr_rot_q[req_idx] <= wr_frac;
		end
		if (we_cel_rot) begin
			cel_rot_q[req_idx] <= wr_frac;
			hlm_rot_q[req_idx] <= wr_hlim;
		end
	end
end

// ==========================================================================
// realm space storage

reg  [`BWC_FRAC_W-1:0] flr_rlm_q [0:`BWC_DEPTH-1];
reg  [`BWC_FRAC_W-1:0] cel_rlm_q [0:`BWC_DEPTH-1];
reg                    hlm_rlm_q [0:`BWC_DEPTH-1];
wire                   we_flr_rlm;
wire                   we_cel_rlm;
integer                i_rlm;

// only the realm frame reaches these settings
assign we_flr_rlm = wr_flr && (req_space == `BWC_SP_REALM);
assign we_cel_rlm = wr_cel && (req_space == `BWC_SP_REALM);

// realm floor, ceiling and hard-limit settings
always @(posedge mclk) begin
	if (sys_rst) begin
		for (i_rlm = 0; i_rlm < `BWC_DEPTH; i_rlm = i_rlm + 1) begin
			flr_rlm_q[i_rlm] <= `BWC_FRAC_RESET;
			cel_rlm_q[i_rlm] <= `BWC_FRAC_RESET;
			hlm_rlm_q[i_rlm] <= 1'b0;
		end
	end else begin
		if (we_flr_rlm) begin
			flr_rlm_q[req_idx] <= wr_frac;
		end
		if (we_cel_rlm) begin
			cel_rlm_q[req_idx] <= wr_frac;
			hlm_rlm_q[req_idx] <= wr_hlim;
		end
	end
end

// ==========================================================================
// read ports of the four spaces, secure lowest

// software reads follow the selector, lookups follow the arbiter key
assign flr_rd_all  = {flr_rlm_q[req_idx], flr_rot_q[req_idx],
	flr_nsc_q[req_idx], flr_sec_q[req_idx]};
assign cel_rd_all  = {cel_rlm_q[req_idx], cel_rot_q[req_idx],
	cel_nsc_q[req_idx], cel_sec_q[req_idx]};
assign hl_rd_all   = {hlm_rlm_q[req_idx], hlm_rot_q[req_idx],
	hlm_nsc_q[req_idx], hlm_sec_q[req_idx]};
assign flr_arb_all = {flr_rlm_q[arb_idx], flr_rot_q[arb_idx],
	flr_nsc_q[arb_idx], flr_sec_q[arb_idx]};
assign cel_arb_all = {cel_rlm_q[arb_idx], cel_rot_q[arb_idx],
	cel_nsc_q[arb_idx], cel_sec_q[arb_idx]};
assign hl_arb_all  = {hlm_rlm_q[arb_idx], hlm_rot_q[arb_idx],
	hlm_nsc_q[arb_idx], hlm_sec_q[arb_idx]};

// ==========================================================================
// read data assembly

reg [31:0] rd_word;

// reserved bits forced to zero, absent registers read zero
always @* begin
	rd_word = `BWC_WORD_ZERO;
	if (acc_ok && hit_flr) begin
		rd_word = {`BWC_RSVD_FLR,
			flr_rd_all[req_space*`BWC_FRAC_W +: `BWC_FRAC_W]};
	end else if (acc_ok && hit_cel) begin
		rd_word = {hl_rd_all[req_space], `BWC_RSVD_CEIL,
			cel_rd_all[req_space*`BWC_FRAC_W +: `BWC_FRAC_W]};
	end
end

// one-cycle answer to every access
always @(posedge mclk) begin
	if (sys_rst) begin
		rsp_valid_q <= 1'b0;
		rsp_rdata_q <= `BWC_WORD_ZERO;
		sel_error_q <= 1'b0;
	end else begin
		rsp_valid_q <= req_valid;
		sel_error_q <= req_valid && (hit_flr || hit_cel) && !sel_ok;
		if (req_valid && !req_write) begin
			rsp_rdata_q <= rd_word;
		end else begin
			rsp_rdata_q <= `BWC_WORD_ZERO;
		end
	end
end

// ==========================================================================
// arbiter preference lookup

reg  [15:0] arb_floor;
reg  [15:0] arb_ceil;
reg         arb_hl;
reg         arb_space_ok;
reg         over_ceil;

// select the settings of the requesting partition
always @* begin
	arb_floor    = flr_arb_all[arb_space*`BWC_FRAC_W +: `BWC_FRAC_W];
	arb_ceil     = cel_arb_all[arb_space*`BWC_FRAC_W +: `BWC_FRAC_W];
	arb_hl       = hl_arb_all[arb_space];
	arb_space_ok = 1'b1;
	if (arb_space == `BWC_SP_ROOT) begin
		arb_space_ok = (realm_management_feature != 0);
	end
	over_ceil = CEL_ON && arb_space_ok && (arb_usage > arb_ceil);
end

// registered preference outcome
always @(posedge mclk) begin
	if (sys_rst) begin
		arb_valid_q    <= 1'b0;
		arb_prefer_q   <= 1'b0;
		arb_low_pref_q <= 1'b0;
		arb_block_q    <= 1'b0;
	end else begin
		arb_valid_q    <= arb_valid;
		arb_prefer_q   <= arb_valid && FLR_ON && arb_space_ok
			&& (arb_usage < arb_floor);
		arb_block_q    <= arb_valid && over_ceil && arb_hl;
		arb_low_pref_q <= arb_valid && over_ceil && !arb_hl;
	end
end

endmodule

// *** dv/bwc_monitor.sv ***
// assertion checker for the bandwidth floor and ceiling store
module bwc_monitor #(
	parameter       narrowing_present  = 0,
	parameter [4:0] fraction_bit_width = 8
) (
	input logic        mclk,
	input logic        sys_rst,
	input logic        req_valid,
	input logic        req_write,
	input logic [15:0] req_addr,
	input logic        sel_internal,
	input logic        arb_valid,
	input logic [15:0] arb_usage,
	input logic        rsp_valid_q,
	input logic [31:0] rsp_rdata_q,
	input logic        sel_error_q,
	input logic        arb_valid_q,
	input logic        arb_prefer_q,
	input logic        arb_low_pref_q,
	input logic        arb_block_q
);
	localparam [15:0] LOW_MASK = 16'hFFFF >> fraction_bit_width;
	// read strobe and floor or ceiling decode
	wire rd = req_valid && !req_write;
	wire fc = (req_addr == 16'h0200) || (req_addr == 16'h0208);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ==========
	// register access answers
	rsp_pulse_a: assert property (req_valid |=> rsp_valid_q) else $error("no answer");
	rsp_quiet_a: assert property (!req_valid |=> !rsp_valid_q) else $error("stray answer");
	wr_zero_a: assert property (req_valid && req_write |=> rsp_rdata_q == 32'h0)
		else $error("write gave data");
	unmapped_zero_a: assert property (req_valid && !fc |=> rsp_rdata_q == 32'h0)
		else $error("unmapped gave data");
	floor_rsvd_a: assert property (rd && req_addr == 16'h0200
		|=> rsp_rdata_q[31:16] == 16'h0) else $error("floor reserved set");
	ceil_rsvd_a: assert property (rd && req_addr == 16'h0208
		|=> rsp_rdata_q[30:16] == 15'h0) else $error("ceiling reserved set");
	low_bits_a: assert property (rd && fc |=> (rsp_rdata_q[15:0] & LOW_MASK) == 16'h0)
		else $error("low fraction bits set");
	sel_err_a: assert property (req_valid && fc && sel_internal != (narrowing_present != 0)
		|=> sel_error_q) else $error("selector flag unflagged");
	sel_quiet_a: assert property (!req_valid |=> !sel_error_q) else $error("stray error");
	// ==========
	// arbiter lookup answers
	arb_pulse_a: assert property (arb_valid |=> arb_valid_q) else $error("no lookup answer");
	full_use_a: assert property (arb_valid && arb_usage == 16'hFFFF |=> !arb_prefer_q)
		else $error("preferred at full use");
	zero_use_a: assert property (arb_valid && arb_usage == 16'h0
		|=> !arb_block_q && !arb_low_pref_q) else $error("limited at zero use");
	limit_excl_a: assert property (arb_valid_q |-> !(arb_block_q && arb_low_pref_q))
		else $error("block and low preference together");
endmodule

// *** dv/bwc_top_tb.sv ***
// self-checking testbench for the bandwidth floor and ceiling store
module bwc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, sys_rst = 1, req_valid = 0, req_write = 0, sel_internal = 0;
	logic        arb_valid = 0, isel = 0, arb_instance = 0, rsp_valid_q, sel_error_q;
	logic        arb_valid_q, arb_prefer_q, arb_low_pref_q, arb_block_q;
	logic [1:0]  req_space = 0, arb_space = 0;
	logic [3:0]  arb_partition = 0;
	logic [15:0] req_addr = 0, pid = 0, arb_usage = 0;
	logic [31:0] req_wdata = 0, rsp_rdata_q;
	int          failures = 0, checks = 0;
	bwc_top DUT (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
		.req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata),
		.selected_partition_field(pid), .resource_instance_select(isel),
		.sel_internal(sel_internal), .arb_valid(arb_valid), .arb_space(arb_space),
		.arb_instance(arb_instance), .arb_partition(arb_partition), .arb_usage(arb_usage),
		.rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .sel_error_q(sel_error_q),
		.arb_valid_q(arb_valid_q), .arb_prefer_q(arb_prefer_q),
		.arb_low_pref_q(arb_low_pref_q), .arb_block_q(arb_block_q));
	// 250 MHz clock
	always #2 mclk = ~mclk;
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one access: drive at falling edge, judge the one-cycle answer
	task automatic acc(input logic [1:0] s, input logic w, input logic [15:0] a, p,
		input logic r, input logic [31:0] d, exp, input logic e);
		@(negedge mclk);
		{req_valid, req_write, req_space, req_addr, pid, isel, req_wdata} = {1'b1, w, s, a, p, r, d};
		@(negedge mclk);
		req_valid = 0;
		chk({rsp_valid_q, sel_error_q}, {1'b1, e});
		if (!w) chk(rsp_rdata_q, exp);
	endtask
	// one lookup of space 1, partition 7: {valid, prefer, block, low}
	task automatic lk(input logic [15:0] u, input logic [3:0] exp);
		@(negedge mclk);
		{arb_valid, arb_space, arb_instance, arb_partition, arb_usage} = {1'b1, 2'h1, 1'b0, 4'h7, u};
		@(negedge mclk);
		arb_valid = 0;
		chk({arb_valid_q, arb_prefer_q, arb_block_q, arb_low_pref_q}, exp);
	endtask
	// ==========
	// scenarios
	task automatic t_spaces();
		for (int s = 0; s < 4; s++) begin
			acc(2'(s), 1, 16'h0200, 16'h0005, 1, {16'hFFFF, 4'(s), 12'hFFF}, 0, 0);
			acc(2'(s), 1, 16'h0208, 16'h0005, 1, {s[0], 15'h7FFF, 4'(s), 12'hABC}, 0, 0);
		end
		for (int s = 0; s < 4; s++) begin
			acc(2'(s), 0, 16'h0200, 16'h0005, 1, 0, {16'h0, 4'(s), 12'hF00}, 0);
			acc(2'(s), 0, 16'h0208, 16'h0005, 1, 0, {s[0], 15'h0, 4'(s), 12'hA00}, 0);
			acc(2'(s), 0, 16'h0200, 16'h0005, 0, 0, 0, 0);
		end
		$display("spaces test done");
	endtask
	task automatic t_refuse();
		acc(1, 1, 16'h0204, 16'h0002, 0, 32'hFFFF_FFFF, 0, 0);
		acc(1, 0, 16'h0204, 16'h0002, 0, 0, 0, 0);
		sel_internal = 1;
		acc(1, 1, 16'h0200, 16'h0002, 0, 32'h0000_FF00, 0, 1);
		sel_internal = 0;
		acc(1, 0, 16'h0200, 16'h0002, 0, 0, 0, 0);
		acc(1, 1, 16'h0200, 16'h0012, 0, 32'h0000_FF00, 0, 0);
		acc(1, 0, 16'h0200, 16'h0002, 0, 0, 0, 0);
		acc(0, 1, 16'h0200, 16'h0003, 0, 32'hFFFF_FFFF, 0, 0);
		acc(0, 0, 16'h0200, 16'h0003, 0, 0, 32'h0000_FF00, 0);
		acc(0, 1, 16'h0208, 16'h0003, 0, 32'hFFFF_FFFF, 0, 0);
		acc(0, 0, 16'h0208, 16'h0003, 0, 0, 32'h8000_FF00, 0);
		$display("refusal test done");
	endtask
	task automatic t_arb();
		acc(1, 1, 16'h0200, 16'h0007, 0, 32'h0000_4000, 0, 0);
		acc(1, 1, 16'h0208, 16'h0007, 0, 32'h8000_8000, 0, 0);
		lk(16'h0000, 4'hC);
		lk(16'h3F00, 4'hC);
		lk(16'h4000, 4'h8);
		lk(16'h9000, 4'hA);
		acc(1, 1, 16'h0208, 16'h0007, 0, 32'h0000_8000, 0, 0);
		lk(16'hFFFF, 4'h9);
		lk(16'h8000, 4'h8);
		$display("arbiter test done");
	endtask
	// print counts and verdict
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 0;
		t_spaces();
		t_refuse();
		t_arb();
		end_sim();
	end
	// cut a hung run short
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		end_sim();
	end
endmodule
bind bwc_top bwc_monitor #(.narrowing_present(narrowing_present),
	.fraction_bit_width(fraction_bit_width)) u_mon (.mclk(mclk), .sys_rst(sys_rst),
	.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
	.sel_internal(sel_internal), .arb_valid(arb_valid), .arb_usage(arb_usage),
	.rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .sel_error_q(sel_error_q),
	.arb_valid_q(arb_valid_q), .arb_prefer_q(arb_prefer_q),
	.arb_low_pref_q(arb_low_pref_q), .arb_block_q(arb_block_q));
